// >>> hw/mbps_pkg.sv
/*
  Shared constants for the serial port setup logic: the positions of the
  setting registers in the module database, their values after
  initialization, port roles, function codes, fault codes and the
  millisecond timebase.
  Assumes a single 20 MHz system clock.
*/
package mbps_pkg;

  // Timebase
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

  // Database locations of the port setting registers
  localparam logic [15:0] CTS_GATING_CFG_OFS = 16'h139f;
  localparam logic [15:0] NODE_ADDRESS_CFG_OFS = 16'h13a0;
  localparam logic [15:0] DISCRETE_INPUT_BASE_OFS = 16'h13a1;
  localparam logic [15:0] INPUT_REGISTER_BASE_OFS = 16'h13a2;
  localparam logic [15:0] COIL_BASE_OFS = 16'h13a3;
  localparam logic [15:0] HOLDING_REGISTER_BASE_OFS = 16'h13a4;
  localparam logic [15:0] MASTER_CMD_TOTAL_OFS = 16'h13a5;
  localparam logic [15:0] INTER_CMD_GAP_MS_OFS = 16'h13a6;
  localparam logic [15:0] CMD_FAULT_LOCATION_OFS = 16'h13a7;
  localparam logic [15:0] REPLY_WAIT_MS_OFS = 16'h13a8;
  localparam logic [15:0] RESEND_LIMIT_OFS = 16'h13a9;
  localparam logic [15:0] SKIP_POLLS_AFTER_FAIL_OFS = 16'h13aa;
  localparam logic [15:0] LINE_IDLE_TIMEOUT_MS_OFS = 16'h13cc;

  // Values held after initialization
  localparam logic [15:0] CTS_GATING_RST = 16'h0000;
  localparam logic [15:0] NODE_ADDRESS_RST = 16'h0001;
  localparam logic [15:0] BASE_OFFSET_RST = 16'h0000;
  localparam logic [15:0] CMD_TOTAL_RST = 16'h0000;
  localparam logic [15:0] GAP_MS_RST = 16'h0000;
  localparam logic [15:0] FAULT_LOCATION_RST = 16'hffff;
  localparam logic [15:0] REPLY_WAIT_RST = 16'h03e8;
  localparam logic [15:0] RESEND_LIMIT_RST = 16'h0003;
  localparam logic [15:0] SKIP_POLLS_RST = 16'h0000;
  localparam logic [15:0] IDLE_TIMEOUT_RST = 16'h0000;

  // Field limits
  localparam int CTS_GATE_BIT = 0;
  localparam logic [15:0] FAULT_LOCATION_MAX = 16'h1387;
  localparam logic [15:0] NODE_ADDRESS_MAX = 16'h00ff;

  // Port roles
  localparam logic [1:0] ROLE_MASTER = 2'h0;

  // Function codes served by the slave side
  localparam logic [7:0] FN_READ_COILS = 8'h01;
  localparam logic [7:0] FN_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FN_READ_HOLDING = 8'h03;
  localparam logic [7:0] FN_READ_INPUT = 8'h04;
  localparam logic [7:0] FN_WRITE_COIL = 8'h05;
  localparam logic [7:0] FN_WRITE_HOLDING = 8'h06;
  localparam logic [7:0] FN_WRITE_COILS = 8'h0f;
  localparam logic [7:0] FN_WRITE_HOLDINGS = 8'h10;

  // Fault codes logged per master command
  localparam logic [15:0] FAULT_NONE_CODE = 16'h0000;
  localparam logic [15:0] FAULT_TIMEOUT_CODE = 16'h00fe;

endpackage

// >>> hw/mbps_ms_timer.sv
/*
  Restartable millisecond counter. Counts whole milliseconds since the
  last restart and saturates.
  Assumes the restart strobe comes from logic on the same clock.
*/
`timescale 1ns/1ns
module mbps_ms_timer #(
  parameter int MS_CYCLES = 20000
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  output logic [15:0] ms_count_out
);

  localparam int PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  logic [PRE_W-1:0] pre_q;

  if (MS_CYCLES < 1) begin : g_bad_cycles
    $error("MS_CYCLES must be at least one");
  end

  // Prescaler realigned on restart so every wait starts on a clean edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_q <= '0;
    end else if (restart_in || pre_q == PRE_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Saturates so a long silence never wraps back to a short time
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ms_count_out <= 16'h0000;
    end else if (restart_in) begin
      ms_count_out <= 16'h0000;
    end else if (pre_q == PRE_LAST && ms_count_out != 16'hffff) begin
      ms_count_out <= ms_count_out + 16'h0001;
    end
  end

endmodule

// >>> hw/mbps_port.sv
/*
  Setup-driven behaviour of one serial port: setting registers in the
  module database, slave address filtering and database mapping, master
  command sequencing with gap, timeout, retries, fault logging and
  per-slave back-off, clear-to-send gating and the line idle timeout.
  Assumes framing, baud and modem timing live outside; the command list
  is looked up outside from CMD_INDEX_OUT on the same clock.
*/
`timescale 1ns/1ns
module mbps_port
  import mbps_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CFG_WR_IN,
  input wire logic [15:0] CFG_ADDR_IN,
  input wire logic [15:0] CFG_WDATA_IN,
  output logic [15:0] CFG_RDATA_OUT,
  input wire logic [1:0] PORT_ROLE_IN,
  input wire logic CTS_IN,
  input wire logic TX_READY_IN,
  output logic TX_GO_OUT,
  input wire logic REQ_VALID_IN,
  input wire logic [7:0] REQ_NODE_IN,
  input wire logic [7:0] REQ_FUNC_IN,
  input wire logic [15:0] REQ_ADDR_IN,
  output logic REQ_ACCEPT_OUT,
  output logic REQ_BAD_FUNC_OUT,
  output logic [15:0] REQ_DB_ADDR_OUT,
  output logic [15:0] CMD_INDEX_OUT,
  input wire logic [7:0] CMD_SLAVE_IN,
  output logic CMD_SEND_OUT,
  input wire logic RSP_OK_IN,
  output logic ERR_WR_OUT,
  output logic [15:0] ERR_ADDR_OUT,
  output logic [15:0] ERR_CODE_OUT,
  input wire logic RX_BYTE_IN,
  input wire logic [15:0] BAUD_GUARD_MS_IN,
  output logic FRAME_END_OUT
);

  typedef enum logic [2:0] {M_IDLE, M_FETCH, M_SEND, M_WAIT, M_LOG, M_GAP, M_NEXT} mbps_mst_t;

  logic [15:0] cts_cfg_q, node_q, di_base_q, ir_base_q, coil_base_q, hr_base_q;
  logic [15:0] cmd_total_q, gap_q, fault_loc_q, reply_wait_q, resend_q, skip_cfg_q;
  logic [15:0] idle_cfg_q;
  logic cts_meta_q, cts_sync_q, tx_permit, is_master;
  mbps_mst_t mst_q;
  logic [15:0] retry_q, code_q, mst_ms, guard_ms, guard_lim;
  logic [7:0] slave_q;
  logic [15:0] skip_mem [256];
  logic skip_set, skip_clr, skip_dec, mst_restart, guard_armed_q;
  logic fn_ok;
  logic [15:0] fn_base;

  // Settings loaded at initialization, rewritable later
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cts_cfg_q <= CTS_GATING_RST;
      node_q <= NODE_ADDRESS_RST;
      di_base_q <= BASE_OFFSET_RST;
      ir_base_q <= BASE_OFFSET_RST;
      coil_base_q <= BASE_OFFSET_RST;
      hr_base_q <= BASE_OFFSET_RST;
      cmd_total_q <= CMD_TOTAL_RST;
      gap_q <= GAP_MS_RST;
      fault_loc_q <= FAULT_LOCATION_RST;
      reply_wait_q <= REPLY_WAIT_RST;
      resend_q <= RESEND_LIMIT_RST;
      skip_cfg_q <= SKIP_POLLS_RST;
      idle_cfg_q <= IDLE_TIMEOUT_RST;
    end else if (CFG_WR_IN) begin
      unique case (CFG_ADDR_IN)
        CTS_GATING_CFG_OFS: cts_cfg_q <= CFG_WDATA_IN;
        NODE_ADDRESS_CFG_OFS: node_q <= CFG_WDATA_IN;
        DISCRETE_INPUT_BASE_OFS: di_base_q <= CFG_WDATA_IN;
        INPUT_REGISTER_BASE_OFS: ir_base_q <= CFG_WDATA_IN;
        COIL_BASE_OFS: coil_base_q <= CFG_WDATA_IN;
        HOLDING_REGISTER_BASE_OFS: hr_base_q <= CFG_WDATA_IN;
        MASTER_CMD_TOTAL_OFS: cmd_total_q <= CFG_WDATA_IN;
        INTER_CMD_GAP_MS_OFS: gap_q <= CFG_WDATA_IN;
        CMD_FAULT_LOCATION_OFS: fault_loc_q <= CFG_WDATA_IN;
        REPLY_WAIT_MS_OFS: reply_wait_q <= CFG_WDATA_IN;
        RESEND_LIMIT_OFS: resend_q <= CFG_WDATA_IN;
        SKIP_POLLS_AFTER_FAIL_OFS: skip_cfg_q <= CFG_WDATA_IN;
        LINE_IDLE_TIMEOUT_MS_OFS: idle_cfg_q <= CFG_WDATA_IN;
        default: ;
      endcase
    end
  end

  // Read-back; other database locations answer zero here
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      CFG_RDATA_OUT <= 16'h0000;
    end else begin
      unique case (CFG_ADDR_IN)
        CTS_GATING_CFG_OFS: CFG_RDATA_OUT <= cts_cfg_q;
        NODE_ADDRESS_CFG_OFS: CFG_RDATA_OUT <= node_q;
        DISCRETE_INPUT_BASE_OFS: CFG_RDATA_OUT <= di_base_q;
        INPUT_REGISTER_BASE_OFS: CFG_RDATA_OUT <= ir_base_q;
        COIL_BASE_OFS: CFG_RDATA_OUT <= coil_base_q;
        HOLDING_REGISTER_BASE_OFS: CFG_RDATA_OUT <= hr_base_q;
        MASTER_CMD_TOTAL_OFS: CFG_RDATA_OUT <= cmd_total_q;
        INTER_CMD_GAP_MS_OFS: CFG_RDATA_OUT <= gap_q;
        CMD_FAULT_LOCATION_OFS: CFG_RDATA_OUT <= fault_loc_q;
        REPLY_WAIT_MS_OFS: CFG_RDATA_OUT <= reply_wait_q;
        RESEND_LIMIT_OFS: CFG_RDATA_OUT <= resend_q;
        SKIP_POLLS_AFTER_FAIL_OFS: CFG_RDATA_OUT <= skip_cfg_q;
        LINE_IDLE_TIMEOUT_MS_OFS: CFG_RDATA_OUT <= idle_cfg_q;
        default: CFG_RDATA_OUT <= 16'h0000;
      endcase
    end
  end

  // CTS is a modem pin, so two flops before use
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cts_meta_q <= 1'b0;
      cts_sync_q <= 1'b0;
    end else begin
      cts_meta_q <= CTS_IN;
      cts_sync_q <= cts_meta_q;
    end
  end

  // Only the gating bit is honoured; upper bits are don't-care
  assign tx_permit = cts_cfg_q[CTS_GATE_BIT] ? cts_sync_q : 1'b1;
  assign TX_GO_OUT = TX_READY_IN && tx_permit;
  assign is_master = (PORT_ROLE_IN == ROLE_MASTER);

  // Database base selected by function code
  always_comb begin
    fn_ok = 1'b1;
    fn_base = 16'h0000;
    unique case (REQ_FUNC_IN)
      FN_READ_DISCRETE: fn_base = di_base_q;
      FN_READ_INPUT: fn_base = ir_base_q;
      FN_READ_COILS, FN_WRITE_COIL, FN_WRITE_COILS: fn_base = coil_base_q;
      FN_READ_HOLDING, FN_WRITE_HOLDING, FN_WRITE_HOLDINGS: fn_base = hr_base_q;
      default: fn_ok = 1'b0;
    endcase
  end

  // Slave request filter; foreign node addresses are dropped silently
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      REQ_ACCEPT_OUT <= 1'b0;
      REQ_BAD_FUNC_OUT <= 1'b0;
      REQ_DB_ADDR_OUT <= 16'h0000;
    end else begin
      REQ_ACCEPT_OUT <= 1'b0;
      REQ_BAD_FUNC_OUT <= 1'b0;
      if (REQ_VALID_IN && !is_master && node_q != 16'h0000 && node_q <= NODE_ADDRESS_MAX
          && REQ_NODE_IN == node_q[7:0]) begin
        REQ_ACCEPT_OUT <= fn_ok;
        REQ_BAD_FUNC_OUT <= !fn_ok;
        REQ_DB_ADDR_OUT <= REQ_ADDR_IN + fn_base;
      end
    end
  end

  assign mst_restart = (mst_q == M_SEND && tx_permit) || mst_q == M_LOG;
  assign CMD_SEND_OUT = (mst_q == M_SEND) && tx_permit;

  mbps_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_mst_timer (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .restart_in(mst_restart),
    .ms_count_out(mst_ms)
  );

  // Back-off table writes
  assign skip_dec = (mst_q == M_FETCH) && skip_mem[CMD_SLAVE_IN] != 16'h0000;
  assign skip_clr = (mst_q == M_WAIT) && RSP_OK_IN;
  assign skip_set = (mst_q == M_WAIT) && !RSP_OK_IN && mst_ms >= reply_wait_q
                    && retry_q >= resend_q;

  // Master sequencer
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      mst_q <= M_IDLE;
      CMD_INDEX_OUT <= 16'h0000;
      slave_q <= 8'h00;
      retry_q <= 16'h0000;
      code_q <= FAULT_NONE_CODE;
    end else begin
      unique case (mst_q)
        M_IDLE: begin
          CMD_INDEX_OUT <= 16'h0000;
          if (is_master && cmd_total_q != 16'h0000) begin
            mst_q <= M_FETCH;
          end
        end
        M_FETCH: begin
          slave_q <= CMD_SLAVE_IN;
          retry_q <= 16'h0000;
          mst_q <= skip_dec ? M_NEXT : M_SEND;
        end
        M_SEND: begin
          if (tx_permit) begin
            mst_q <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (RSP_OK_IN) begin
            code_q <= FAULT_NONE_CODE;
            mst_q <= M_LOG;
          end else if (mst_ms >= reply_wait_q) begin
            if (retry_q < resend_q) begin
              retry_q <= retry_q + 16'h0001;
              mst_q <= M_SEND;
            end else begin
              code_q <= FAULT_TIMEOUT_CODE;
              mst_q <= M_LOG;
            end
          end
        end
        M_LOG: mst_q <= M_GAP;
        M_GAP: begin
          if (mst_ms >= gap_q) begin
            mst_q <= M_NEXT;
          end
        end
        M_NEXT: begin
          // Index wraps at the count so entries beyond it never run
          if (CMD_INDEX_OUT + 16'h0001 >= cmd_total_q) begin
            CMD_INDEX_OUT <= 16'h0000;
          end else begin
            CMD_INDEX_OUT <= CMD_INDEX_OUT + 16'h0001;
          end
          mst_q <= (is_master && cmd_total_q != 16'h0000) ? M_FETCH : M_IDLE;
        end
      endcase
    end
  end

  // Per-slave skip counters; a good reply lifts the suspension at once
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < 256; i++) begin
        skip_mem[i] <= 16'h0000;
      end
    end else if (skip_clr) begin
      skip_mem[slave_q] <= 16'h0000;
    end else if (skip_set) begin
      skip_mem[slave_q] <= skip_cfg_q;
    end else if (skip_dec) begin
      skip_mem[CMD_SLAVE_IN] <= skip_mem[CMD_SLAVE_IN] - 16'h0001;
    end
  end

  // Fault log write; out-of-range locations, -1 included, are never written
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ERR_WR_OUT <= 1'b0;
      ERR_ADDR_OUT <= 16'h0000;
      ERR_CODE_OUT <= FAULT_NONE_CODE;
    end else begin
      ERR_WR_OUT <= (mst_q == M_LOG) && fault_loc_q <= FAULT_LOCATION_MAX;
      if (mst_q == M_LOG) begin
        ERR_ADDR_OUT <= fault_loc_q + CMD_INDEX_OUT;
        ERR_CODE_OUT <= code_q;
      end
    end
  end

  // Line idle timeout, zero falls back to the baud-derived figure
  assign guard_lim = (idle_cfg_q == 16'h0000) ? BAUD_GUARD_MS_IN : idle_cfg_q;

  mbps_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_guard_timer (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .restart_in(RX_BYTE_IN),
    .ms_count_out(guard_ms)
  );

  // One end-of-frame pulse per burst of received bytes
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      guard_armed_q <= 1'b0;
      FRAME_END_OUT <= 1'b0;
    end else begin
      FRAME_END_OUT <= guard_armed_q && !RX_BYTE_IN && guard_ms >= guard_lim;
      if (RX_BYTE_IN) begin
        guard_armed_q <= 1'b1;
      end else if (guard_ms >= guard_lim) begin
        guard_armed_q <= 1'b0;
      end
    end
  end

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_timed_out;
    mst_q == M_WAIT && !RSP_OK_IN && mst_ms >= reply_wait_q;
  endsequence
  sequence s_retry_left;
    retry_q < resend_q;
  endsequence

  role_master_a: assert property (CMD_SEND_OUT |-> is_master)
    else $error("send as slave");
  cts_hold_a: assert property (cts_cfg_q[CTS_GATE_BIT] && !cts_sync_q |->
    !TX_GO_OUT && !CMD_SEND_OUT) else $error("sent while CTS low");
  cts_ignore_a: assert property (!cts_cfg_q[CTS_GATE_BIT] && TX_READY_IN |-> TX_GO_OUT)
    else $error("CTS not ignored");
  node_match_a: assert property (REQ_ACCEPT_OUT |->
    $past(REQ_NODE_IN) == node_q[7:0] && $past(!is_master))
    else $error("foreign node accepted");
  map_discrete_a: assert property (REQ_VALID_IN && REQ_FUNC_IN == FN_READ_DISCRETE |=>
    !REQ_ACCEPT_OUT || REQ_DB_ADDR_OUT == $past(REQ_ADDR_IN) + di_base_q)
    else $error("discrete map wrong");
  map_input_a: assert property (REQ_VALID_IN && REQ_FUNC_IN == FN_READ_INPUT |=>
    !REQ_ACCEPT_OUT || REQ_DB_ADDR_OUT == $past(REQ_ADDR_IN) + ir_base_q)
    else $error("input map wrong");
  map_coil_a: assert property (REQ_VALID_IN && REQ_FUNC_IN == FN_WRITE_COILS |=>
    !REQ_ACCEPT_OUT || REQ_DB_ADDR_OUT == $past(REQ_ADDR_IN) + coil_base_q)
    else $error("coil map wrong");
  map_holding_a: assert property (REQ_VALID_IN && REQ_FUNC_IN == FN_WRITE_HOLDINGS |=>
    !REQ_ACCEPT_OUT || REQ_DB_ADDR_OUT == $past(REQ_ADDR_IN) + hr_base_q)
    else $error("holding map wrong");
  cmd_bound_a: assert property (CMD_SEND_OUT |-> CMD_INDEX_OUT < cmd_total_q)
    else $error("index past count");
  retry_direct_a: assert property (s_timed_out ##0 s_retry_left |=>
    mst_q == M_SEND) else $error("retry delayed or lost");
  fault_suppress_a: assert property (ERR_WR_OUT |-> $past(fault_loc_q) != 16'hffff)
    else $error("fault write not suppressed");
  suspend_slave_a: assert property (s_timed_out ##0 retry_q >= resend_q |=>
    skip_mem[slave_q] == $past(skip_cfg_q) ##1 mst_q == M_GAP)
    else $error("no suspend");
  skip_poll_a: assert property (mst_q == M_FETCH && skip_mem[CMD_SLAVE_IN] != 16'h0000 |=>
    mst_q == M_NEXT ##1 !CMD_SEND_OUT) else $error("suspended slave polled");
  guard_end_a: assert property (FRAME_END_OUT |-> $past(guard_ms) >= $past(guard_lim))
    else $error("frame ended early");

endmodule

// >>> testbench/mbps_far_node.sv
/*
  Model of the remote slave nodes seen by the master side: it looks up the
  slave address of each command and answers a send after a short delay.
  Assumes it runs on the port clock and is told when to stay silent.
*/
`timescale 1ns/1ns
module mbps_far_node (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic send_in,
  input wire logic silent_in,
  input wire logic [15:0] index_in,
  output logic rsp_ok_out,
  output logic [7:0] slave_out
);
  logic [3:0] dly_q;
  logic busy_q;
  // One distinct node per command, so back-off never hits two commands
  assign slave_out = 8'h20 + index_in[7:0];
  // Reply five cycles after a send, well inside the timeout
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_q <= 1'b0;
      dly_q <= 4'h0;
      rsp_ok_out <= 1'b0;
    end else begin
      rsp_ok_out <= 1'b0;
      if (send_in && !(silent_in && !index_in[0])) begin // Silence hits even commands only
        busy_q <= 1'b1;
        dly_q <= 4'h4;
      end else if (busy_q) begin
        if (dly_q == 4'h0) begin
          busy_q <= 1'b0;
          rsp_ok_out <= 1'b1;
        end else begin
          dly_q <= dly_q - 4'h1;
        end
      end
    end
  end
endmodule

// >>> testbench/mbps_port_test.sv
/*
  Self-checking bench for the serial port setup logic: settings, slave
  mapping, clear-to-send gating, master sequencing and the idle timeout.
  Assumes a 4-cycle millisecond so that timeouts stay short.
*/
`timescale 1ns/1ns
module mbps_port_test;
  import mbps_pkg::*;
  typedef struct packed {logic [7:0] fn; logic [15:0] ad; logic [15:0] db; logic acc;} mbps_row_t;
  localparam int MSC = 4;
  logic clk, rst, cfg_wr, cts, tx_rdy, tx_go, req_v, acc, bad, send, rsp, ewr, rxb, fend, silent;
  logic [15:0] cfg_a, cfg_d, rdata, req_a, db_a, idx, ea, ec, guard;
  logic [7:0] req_n, req_f, cslv;
  logic [1:0] role;
  logic [15:0] ea_log [8];
  logic [15:0] ec_log [8];
  int err_count, n_checks, cyc, last, spacing, n_sends, err_n, c;
  logic [31:0] rst_tab [14] = '{{16'h139f, CTS_GATING_RST}, {16'h13a0, NODE_ADDRESS_RST},
    {16'h13a1, BASE_OFFSET_RST}, {16'h13a2, BASE_OFFSET_RST}, {16'h13a3, BASE_OFFSET_RST},
    {16'h13a4, BASE_OFFSET_RST}, {16'h13a5, CMD_TOTAL_RST}, {16'h13a6, GAP_MS_RST},
    {16'h13a7, FAULT_LOCATION_RST}, {16'h13a8, REPLY_WAIT_RST}, {16'h13a9, RESEND_LIMIT_RST},
    {16'h13aa, SKIP_POLLS_RST}, {16'h13cc, IDLE_TIMEOUT_RST}, {16'h13ab, 16'h0000}};
  // Bases: coil 100, holding 50, discrete 150, input 200
  mbps_row_t rows [9] = '{{8'h02, 16'd0, 16'd150, 1'b1}, {8'h04, 16'd1, 16'd201, 1'b1},
    {8'h01, 16'd2, 16'd102, 1'b1}, {8'h05, 16'd3, 16'd103, 1'b1}, {8'h0f, 16'd4, 16'd104, 1'b1},
    {8'h03, 16'd0, 16'd50, 1'b1}, {8'h06, 16'd7, 16'd57, 1'b1}, {8'h10, 16'd9, 16'd59, 1'b1},
    {8'h07, 16'd0, 16'd0, 1'b0}};

  mbps_port #(.MS_CYCLES(MSC)) i_mbps_port (.SYS_CLK_IN(clk), .RESET_IN(rst),
    .CFG_WR_IN(cfg_wr), .CFG_ADDR_IN(cfg_a), .CFG_WDATA_IN(cfg_d), .CFG_RDATA_OUT(rdata),
    .PORT_ROLE_IN(role), .CTS_IN(cts), .TX_READY_IN(tx_rdy), .TX_GO_OUT(tx_go),
    .REQ_VALID_IN(req_v), .REQ_NODE_IN(req_n), .REQ_FUNC_IN(req_f), .REQ_ADDR_IN(req_a),
    .REQ_ACCEPT_OUT(acc), .REQ_BAD_FUNC_OUT(bad), .REQ_DB_ADDR_OUT(db_a),
    .CMD_INDEX_OUT(idx), .CMD_SLAVE_IN(cslv), .CMD_SEND_OUT(send), .RSP_OK_IN(rsp),
    .ERR_WR_OUT(ewr), .ERR_ADDR_OUT(ea), .ERR_CODE_OUT(ec), .RX_BYTE_IN(rxb),
    .BAUD_GUARD_MS_IN(guard), .FRAME_END_OUT(fend));
  mbps_far_node i_mbps_far_node (.clk_in(clk), .reset_in(rst), .send_in(send),
    .silent_in(silent), .index_in(idx), .rsp_ok_out(rsp), .slave_out(cslv));

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watch sends and fault log writes mid-cycle, where the outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (send === 1'b1) begin
      n_sends++;
      spacing = cyc - last;
      last = cyc;
    end
    if (ewr === 1'b1) begin
      ea_log[err_n[2:0]] = ea;
      ec_log[err_n[2:0]] = ec;
      err_n++;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Leading edge keeps a strobe from being lowered and raised in one time step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    tick(1);
    cfg_a = a;
    cfg_d = d;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask
  task automatic req(input logic [7:0] n, input logic [7:0] f, input logic [15:0] a);
    tick(1);
    req_n = n;
    req_f = f;
    req_a = a;
    req_v = 1'b1;
    tick(1);
    req_v = 1'b0;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    role = 2'h1;
    err_n = 0;
    n_sends = 0;
  endtask
  // Bounded wait on the error log counter
  task automatic wait_err(input int n);
    for (int i = 0; i < 2000 && err_n < n; i++) tick(1);
  endtask
  task automatic final_report();
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(60000 * 50);
    err_count++;
    final_report();
  end

  initial begin
    {cfg_wr, cts, tx_rdy, req_v, rxb, silent} = '0;
    {cfg_a, cfg_d, req_a, guard, req_n, req_f} = '0;
    {err_count, n_checks, cyc, last, spacing, n_sends, err_n} = '0;
    role = 2'h1;
    #2;
    do_reset();
    // Settings after initialization, and an unmapped location
    foreach (rst_tab[i]) begin
      cfg_a = rst_tab[i][31:16];
      tick(2);
      chk(rdata, rst_tab[i][15:0]);
    end
    wr(16'h13a0, 16'd5);
    wr(16'h13a1, 16'd150);
    wr(16'h13a2, 16'd200);
    wr(16'h13a3, 16'd100);
    wr(16'h13a4, 16'd50);
    wr(16'h13ab, 16'h1234);
    tick(2);
    chk(rdata, 16'h0000);
    // Slave mapping per function code, one request every other cycle
    foreach (rows[i]) begin
      req(8'd5, rows[i].fn, rows[i].ad);
      chk(acc, rows[i].acc);
      chk(bad, !rows[i].acc);
      if (rows[i].acc) chk(db_a, rows[i].db);
    end
    // Foreign node and master role are both ignored
    req(8'd6, 8'h03, 16'd0);
    chk({acc, bad}, 16'h0000);
    role = 2'h0;
    req(8'd5, 8'h03, 16'd0);
    chk({acc, bad}, 16'h0000);
    role = 2'h1;
    // Clear-to-send gating on and off
    tx_rdy = 1'b1;
    wr(16'h139f, 16'h0001);
    tick(3);
    chk(tx_go, 1'b0);
    cts = 1'b1;
    tick(3);
    chk(tx_go, 1'b1);
    cts = 1'b0;
    wr(16'h139f, 16'h0000);
    tick(3);
    chk(tx_go, 1'b1);
    cts = 1'b1;
    // Master with answering slaves: two commands, gap 3 ms, log at 10
    wr(16'h13a5, 16'd2);
    wr(16'h13a6, 16'd3);
    wr(16'h13a7, 16'd10);
    wr(16'h13a8, 16'd3);
    wr(16'h13a9, 16'd1);
    err_n = 0;
    n_sends = 0;
    role = 2'h0;
    wait_err(3);
    chk(ea_log[0], 16'd10);
    chk(ec_log[0], FAULT_NONE_CODE);
    chk(ea_log[1], 16'd11);
    chk(ea_log[2], 16'd10);
    chk(16'(spacing >= 3 * MSC), 16'h0001);
    // Second reset mid-run; command 0 goes to a silent slave, command 1 answers
    do_reset();
    silent = 1'b1;
    wr(16'h13a5, 16'h0002);
    wr(16'h13a6, 16'h0014);
    wr(16'h13a7, 16'h000a);
    wr(16'h13a8, 16'h0003);
    wr(16'h13a9, 16'h0001);
    wr(16'h13aa, 16'h0002);
    role = 2'h0;
    wait_err(1);
    chk(ec_log[0], FAULT_TIMEOUT_CODE);
    chk(16'(n_sends), 16'h0002);
    chk(16'(spacing >= 3 * MSC && spacing < 20 * MSC), 16'h0001);
    // Two polls of command 0 are skipped, so command 1 logs three times in a row
    wait_err(5);
    chk(ea_log[1], 16'h000b);
    chk(ec_log[1], FAULT_NONE_CODE);
    chk(ea_log[2], 16'h000b);
    chk(ea_log[3], 16'h000b);
    chk(ea_log[4], 16'h000a);
    chk(ec_log[4], FAULT_TIMEOUT_CODE);
    chk(16'(n_sends), 16'h0007);
    wr(16'h13a7, 16'hffff);
    for (int i = 0; i < 2000 && n_sends < 9; i++) tick(1);
    tick(100);
    chk(16'(err_n), 16'h0005);
    // Idle timeout from baud default, then from the setting
    guard = 16'd2;
    for (int k = 0; k < 2; k++) begin
      rxb = 1'b1;
      tick(1);
      rxb = 1'b0;
      c = 1;
      while (fend !== 1'b1 && c < 60) begin
        tick(1);
        c++;
      end
      chk(16'(c >= (k ? 5 : 2) * MSC && c <= (k ? 5 : 2) * MSC + 3), 16'h0001);
      wr(16'h13cc, 16'd5);
    end
    final_report();
  end
endmodule
